// ==== hw/asc_port_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - channel 7 goes to primary pin when its pin select is 0, else secondary
// - channel 8 goes to primary pin when its pin select is 0, else secondary
// - channel 7 slot code: TDM slot number, or left 0-31 / right 32-63
// - channel 8 slot code likewise; slot fields reset to 6 and 7
// - role 0 means host drives both clocks; role 1 means we drive them
// - automatic clock bit 0 derives settings automatically; 1 uses custom settings
// - in automatic mode PLL runs unless the pll-off bit is set
// - in controller mode clock gate bit holds bit clock and frame sync off
// - controller rate family: 48 kHz when bit 3 is 0, 44.1 kHz otherwise
// - 3-bit field picks reference frequency, valid in automatic controller mode, source mode 0
// - controller configuration register resets to 0x02
// - source mode 0 uses frequency field; 1 uses a frame-rate multiple
// - target, automatic, PLL off: root clock is bit clock or reference clock
module asc_port_top #(
  parameter int BCLK_HALF = asc_pkg::BCLK_HALF_DEF,
  parameter int FRAME_BCLKS = asc_pkg::FRAME_BCLKS_DEF
) (
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_BCLK,
  input wire logic I_FSYNC,
  output logic O_BCLK,
  output logic O_BCLK_OE,
  output logic O_FSYNC,
  output logic O_FSYNC_OE,
  input wire logic [31:0] I_CH7_SAMPLE,
  input wire logic [31:0] I_CH8_SAMPLE,
  output logic O_SAMPLE_TAKE,
  output logic O_PRIMARY_SERIAL_OUT_PIN,
  output logic O_PRIMARY_SERIAL_OUT_PIN_OE,
  output logic O_SECONDARY_OUT_PIN_A,
  output logic O_SECONDARY_OUT_PIN_A_OE,
  output var asc_pkg::asc_clk_cfg_t O_CLK_CFG
);
  localparam int W = asc_pkg::CNT_W;
  localparam int DIV_W = $clog2(BCLK_HALF + 1);
  localparam logic [W-1:0] IDLE = W'(FRAME_BCLKS);
  localparam logic [W-1:0] LAST = W'(FRAME_BCLKS - 1);
  localparam logic [W-1:0] HALF = W'(FRAME_BCLKS / 2);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BCLK_HALF - 1);

  logic [6:0] ch7_q;
  logic [6:0] ch8_q;
  logic [7:0] cfg0_q;
  logic [5:0] port_q;
  logic [31:0] rd_q;
  logic err_q;
  logic [5:0] idx;
  logic setup;
  logic wr_acc;
  logic [6:0] wr_low;
  logic [7:0] stat;
  logic ctrl;
  logic gate;
  logic i2s;

  // ------------------------------------------------------------
  // apb slave, zero wait states
  // ------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a, input logic w);
    logic [5:0] i;
    i = a[7:2];
    mapped = (a[1:0] == 2'h0) && ((i == asc_pkg::IDX_CH7) || (i == asc_pkg::IDX_CH8) ||
      (i == asc_pkg::IDX_CFG0) || (i == asc_pkg::IDX_PORT) ||
      ((i == asc_pkg::IDX_STAT) && !w));
  endfunction

  assign idx = I_PADDR[7:2];
  assign setup = I_PSEL && !I_PENABLE;
  assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE && I_PSTRB[0] && mapped(I_PADDR, 1'b1);
  assign wr_low = I_PWDATA[6:0];

  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      ch7_q <= asc_pkg::CH7_RST;
      ch8_q <= asc_pkg::CH8_RST;
      cfg0_q <= asc_pkg::CFG0_RST;
      port_q <= asc_pkg::PORT_RST;
    end else if (wr_acc) begin
      case (idx)
        asc_pkg::IDX_CH7: ch7_q <= wr_low;
        asc_pkg::IDX_CH8: ch8_q <= wr_low;
        asc_pkg::IDX_CFG0: cfg0_q <= I_PWDATA[7:0];
        asc_pkg::IDX_PORT: port_q <= I_PWDATA[5:0];
        default: ;
      endcase
    end
  end

  // read data is caught in the setup cycle so it comes from a flop
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      rd_q <= 32'h0;
      err_q <= 1'b0;
    end else if (setup) begin
      err_q <= !mapped(I_PADDR, I_PWRITE);
      case (idx)
        asc_pkg::IDX_CH7: rd_q <= {25'h0, ch7_q};
        asc_pkg::IDX_CH8: rd_q <= {25'h0, ch8_q};
        asc_pkg::IDX_CFG0: rd_q <= {24'h0, cfg0_q};
        asc_pkg::IDX_PORT: rd_q <= {26'h0, port_q};
        asc_pkg::IDX_STAT: rd_q <= {24'h0, stat};
        default: rd_q <= 32'h0;
      endcase
    end
  end

  assign O_PRDATA = rd_q;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = err_q && I_PSEL && I_PENABLE;

  // ------------------------------------------------------------
  // bit clock: own divider or synchronised host clock
  // ------------------------------------------------------------
  logic [DIV_W-1:0] div_q;
  logic cbclk_q;
  logic c_tick;
  logic [2:0] bs_q;
  logic [2:0] fs_q;
  logic blvl_q;
  logic flvl_q;
  logic rise;
  logic fall;

  assign ctrl = cfg0_q[asc_pkg::ROLE_BIT];
  assign gate = cfg0_q[asc_pkg::GATE_BIT];
  assign i2s = port_q[1:0] == asc_pkg::FMT_I2S;
  assign c_tick = ctrl && !gate && (div_q == DIV_LAST);

  // gating stops the divider and drops the bit clock at once, so a high phase in progress is cut short
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N || !ctrl || gate) begin
      div_q <= '0;
      cbclk_q <= 1'b0;
    end else if (c_tick) begin
      div_q <= '0;
      cbclk_q <= !cbclk_q;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // a pin level counts once the second and third stages agree
  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      bs_q <= 3'h0;
      fs_q <= 3'h0;
      blvl_q <= 1'b0;
      flvl_q <= 1'b0;
    end else begin
      bs_q <= {bs_q[1:0], I_BCLK};
      fs_q <= {fs_q[1:0], I_FSYNC};
      if (bs_q[1] == bs_q[2]) begin
        blvl_q <= bs_q[2];
      end
      if (fs_q[1] == fs_q[2]) begin
        flvl_q <= fs_q[2];
      end
    end
  end

  always_comb begin
    if (ctrl) begin
      rise = c_tick && !cbclk_q;
      fall = c_tick && cbclk_q;
    end else begin
      rise = (bs_q[1] == bs_q[2]) && bs_q[2] && !blvl_q;
      fall = (bs_q[1] == bs_q[2]) && !bs_q[2] && blvl_q;
    end
  end

  // ------------------------------------------------------------
  // frame position
  // ------------------------------------------------------------
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic fs_prev_q;
  logic start_q;
  logic fs_edge;
  logic frame0;
  logic load;
  logic [W-1:0] pos;
  logic [W-1:0] hpos;
  logic pos_ok;
  logic right;
  logic [5:0] code;
  logic [31:0] smp7_q;
  logic [31:0] smp8_q;
  logic [31:0] smp7_d;
  logic [31:0] smp8_d;
  logic take_q;
  logic cfs_q;
  logic oe_q;

  assign fs_edge = i2s ? (fs_prev_q && !flvl_q) : (!fs_prev_q && flvl_q);
  assign frame0 = ctrl ? (cnt_q >= LAST) : start_q;

  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      fs_prev_q <= 1'b0;
      start_q <= 1'b0;
    end else if (rise) begin
      fs_prev_q <= flvl_q;
      if (!ctrl && fs_edge) begin
        start_q <= 1'b1;
      end
    end else if (fall) begin
      start_q <= 1'b0;
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    if (frame0) begin
      cnt_d = '0;
    end else if (cnt_q != IDLE) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // i2s data trails the frame edge by one bit clock, so the last right bit wraps
  always_comb begin
    pos = (i2s && cnt_d == '0) ? LAST : cnt_d - W'(i2s);
    pos_ok = (cnt_d != IDLE) && !(i2s && cnt_d == '0 && cnt_q != LAST);
    right = (port_q[1:0] != asc_pkg::FMT_TDM) && (pos >= HALF);
    hpos = right ? pos - HALF : pos;
    if (right) begin
      code = {1'b1, hpos[asc_pkg::SLOT_LG+4:asc_pkg::SLOT_LG]};
    end else begin
      code = hpos[asc_pkg::SLOT_LG+5:asc_pkg::SLOT_LG];
    end
  end

  assign load = fall && (cnt_d == W'(i2s)) && (cnt_q != cnt_d);
  assign smp7_d = load ? I_CH7_SAMPLE : smp7_q;
  assign smp8_d = load ? I_CH8_SAMPLE : smp8_q;

  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      cnt_q <= IDLE;
      smp7_q <= 32'h0;
      smp8_q <= 32'h0;
      take_q <= 1'b0;
    end else begin
      take_q <= load;
      smp7_q <= smp7_d;
      smp8_q <= smp8_d;
      if (fall) begin
        cnt_q <= cnt_d;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N || !ctrl || gate) begin
      cfs_q <= 1'b0;
    end else if (fall) begin
      case (port_q[1:0])
        asc_pkg::FMT_TDM: cfs_q <= cnt_d == '0;
        asc_pkg::FMT_I2S: cfs_q <= cnt_d >= HALF;
        default: cfs_q <= cnt_d < HALF;
      endcase
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ctrl;
    end
  end

  assign O_BCLK = cbclk_q;
  assign O_FSYNC = cfs_q;
  assign O_BCLK_OE = oe_q;
  assign O_FSYNC_OE = oe_q;
  assign O_SAMPLE_TAKE = take_q;

  // ------------------------------------------------------------
  // output pins
  // ------------------------------------------------------------
  asc_pkg::asc_lane_cfg_t cfg7;
  asc_pkg::asc_lane_cfg_t cfg8;
  assign cfg7 = {port_q[asc_pkg::EN7_BIT], ch7_q};
  assign cfg8 = {port_q[asc_pkg::EN8_BIT], ch8_q};

  asc_lane #(.PIN(1'b0)) u_pri (
    .i_clk(I_MCLK), .i_rst_n(I_RESET_N), .i_shift(fall), .i_valid(pos_ok),
    .i_code(code), .i_bit(pos[4:0]), .i_cfg7(cfg7), .i_cfg8(cfg8),
    .i_smp7(smp7_d), .i_smp8(smp8_d),
    .o_data(O_PRIMARY_SERIAL_OUT_PIN), .o_oe(O_PRIMARY_SERIAL_OUT_PIN_OE)
  );

  asc_lane #(.PIN(1'b1)) u_sec (
    .i_clk(I_MCLK), .i_rst_n(I_RESET_N), .i_shift(fall), .i_valid(pos_ok),
    .i_code(code), .i_bit(pos[4:0]), .i_cfg7(cfg7), .i_cfg8(cfg8),
    .i_smp7(smp7_d), .i_smp8(smp8_d),
    .o_data(O_SECONDARY_OUT_PIN_A), .o_oe(O_SECONDARY_OUT_PIN_A_OE)
  );

  assign stat = {4'h0, cnt_q != IDLE, O_SECONDARY_OUT_PIN_A_OE,
    O_PRIMARY_SERIAL_OUT_PIN_OE, ctrl && !gate};

  // ------------------------------------------------------------
  // clock configuration handed to the clock tree
  // ------------------------------------------------------------
  logic auto_on;
  logic ref_ok;
  logic pll_off;
  assign auto_on = !cfg0_q[asc_pkg::AUTO_BIT];
  assign pll_off = cfg0_q[asc_pkg::PLLOFF_BIT];
  assign ref_ok = ctrl && auto_on && !port_q[asc_pkg::REFMODE_BIT];

  always_ff @(posedge I_MCLK) begin
    if (!I_RESET_N) begin
      O_CLK_CFG <= '0;
    end else begin
      O_CLK_CFG.controller <= ctrl;
      O_CLK_CFG.auto_derive <= auto_on;
      O_CLK_CFG.pll_enable <= auto_on && !pll_off;
      O_CLK_CFG.family_441 <= ctrl && cfg0_q[asc_pkg::FAM_BIT];
      O_CLK_CFG.ref_valid <= ref_ok;
      O_CLK_CFG.ref_khz <= ref_ok ? asc_pkg::ref_khz(cfg0_q[2:0]) : 15'h0;
      O_CLK_CFG.ref_from_ratio <= ctrl && auto_on && port_q[asc_pkg::REFMODE_BIT];
      O_CLK_CFG.root_valid <= !ctrl && auto_on && pll_off;
      O_CLK_CFG.root_from_refclk <= !ctrl && auto_on && pll_off &&
        port_q[asc_pkg::ROOT_BIT];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);

  sequence s_rd_slot;
    setup && !I_PWRITE && (idx == asc_pkg::IDX_CH7 || idx == asc_pkg::IDX_CH8);
  endsequence
  sequence s_wr_ch7;
    wr_acc && (idx == asc_pkg::IDX_CH7);
  endsequence
  // the clock flops leave reset one edge late, so skip the first edge after release
  sequence s_cfg_still;
    $stable(cfg0_q) && $stable(port_q) && $past(I_RESET_N);
  endsequence

  property p_rst_vals;
    $rose(I_RESET_N) |-> ch7_q == 7'h06 && ch8_q == 7'h07 && cfg0_q == 8'h02;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad reset values");
  property p_wr_ch7;
    s_wr_ch7 |=> ch7_q == $past(wr_low);
  endproperty
  a_wr_ch7: assert property (p_wr_ch7) else $error("ch7 write lost");
  property p_rsvd;
    s_rd_slot ##1 I_PENABLE |-> O_PRDATA[31:7] == 25'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit nonzero");
  property p_target;
    !ctrl ##1 !ctrl |-> !O_BCLK_OE && !O_FSYNC_OE;
  endproperty
  a_target: assert property (p_target) else $error("target drives clocks");
  property p_gate;
    (ctrl && gate) [*2] |-> !O_BCLK && !O_FSYNC && O_BCLK_OE;
  endproperty
  a_gate: assert property (p_gate) else $error("gated clocks moving");
  property p_auto;
    s_cfg_still |-> O_CLK_CFG.auto_derive == auto_on;
  endproperty
  a_auto: assert property (p_auto) else $error("auto flag wrong");
  property p_pll;
    s_cfg_still |-> O_CLK_CFG.pll_enable == (auto_on && !pll_off);
  endproperty
  a_pll: assert property (p_pll) else $error("pll enable wrong");
  property p_family;
    s_cfg_still |-> O_CLK_CFG.family_441 == (ctrl && cfg0_q[3]);
  endproperty
  a_family: assert property (p_family) else $error("rate family wrong");
  property p_ref;
    s_cfg_still |-> O_CLK_CFG.ref_khz == (ref_ok ? asc_pkg::ref_khz(cfg0_q[2:0]) : 15'h0);
  endproperty
  a_ref: assert property (p_ref) else $error("reference frequency wrong");
  property p_root;
    s_cfg_still and (!ctrl && auto_on && pll_off) |->
      O_CLK_CFG.root_valid && O_CLK_CFG.root_from_refclk == port_q[5];
  endproperty
  a_root: assert property (p_root) else $error("root source wrong");
endmodule
`default_nettype wire

// ==== hw/asc_pkg.sv ====
package asc_pkg;
  // ------------------------------------------------------------
  // register map: word index, byte address is four times it
  // ------------------------------------------------------------
  localparam logic [5:0] IDX_CH7 = 6'h11;
  localparam logic [5:0] IDX_CH8 = 6'h12;
  localparam logic [5:0] IDX_CFG0 = 6'h13;
  localparam logic [5:0] IDX_PORT = 6'h30;
  localparam logic [5:0] IDX_STAT = 6'h31;
  localparam logic [6:0] CH7_RST = 7'h06;
  localparam logic [6:0] CH8_RST = 7'h07;
  localparam logic [7:0] CFG0_RST = 8'h02;
  localparam logic [5:0] PORT_RST = 6'h0C;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int PIN_BIT = 6;
  localparam int ROLE_BIT = 7;
  localparam int AUTO_BIT = 6;
  localparam int PLLOFF_BIT = 5;
  localparam int GATE_BIT = 4;
  localparam int FAM_BIT = 3;
  localparam int EN7_BIT = 2;
  localparam int EN8_BIT = 3;
  localparam int REFMODE_BIT = 4;
  localparam int ROOT_BIT = 5;
  localparam logic [1:0] FMT_TDM = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h1;
  localparam logic [1:0] FMT_LJ = 2'h2;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int BCLK_NS_DEF = 64;
  localparam int BCLK_HALF_DEF = BCLK_NS_DEF / (2 * CLK_NS);
  localparam int FRAME_BCLKS_DEF = 256;
  localparam int SLOT_LG = 5;
  localparam int CNT_W = 12;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic pin;
    logic [5:0] slot;
  } asc_lane_cfg_t;
  typedef struct packed {
    logic controller;
    logic auto_derive;
    logic pll_enable;
    logic family_441;
    logic ref_valid;
    logic [14:0] ref_khz;
    logic ref_from_ratio;
    logic root_valid;
    logic root_from_refclk;
  } asc_clk_cfg_t;
  function automatic logic [14:0] ref_khz(input logic [2:0] code);
    case (code)
      3'h0: ref_khz = 15'h2EE0;
      3'h1: ref_khz = 15'h3000;
      3'h2: ref_khz = 15'h32C8;
      3'h3: ref_khz = 15'h3E80;
      3'h4: ref_khz = 15'h4B00;
      3'h5: ref_khz = 15'h4CE0;
      3'h6: ref_khz = 15'h5DC0;
      default: ref_khz = 15'h6000;
    endcase
  endfunction
endpackage

// ==== hw/asc_lane.sv ====
`timescale 1ns/100ps
`default_nettype none
module asc_lane #(
  parameter logic PIN = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_shift,
  input wire logic i_valid,
  input wire logic [5:0] i_code,
  input wire logic [4:0] i_bit,
  input wire asc_pkg::asc_lane_cfg_t i_cfg7,
  input wire asc_pkg::asc_lane_cfg_t i_cfg8,
  input wire logic [31:0] i_smp7,
  input wire logic [31:0] i_smp8,
  output logic o_data,
  output logic o_oe
);
  logic hit7;
  logic hit8;
  logic exp7;
  logic exp8;

  function automatic logic hit(input asc_pkg::asc_lane_cfg_t c, input logic [5:0] code);
    hit = c.en && (c.pin == PIN) && (c.slot == code);
  endfunction

  assign hit7 = i_valid && hit(i_cfg7, i_code);
  assign hit8 = i_valid && hit(i_cfg8, i_code);
  // msb first within the slot
  assign exp7 = i_smp7[~i_bit];
  assign exp8 = i_smp8[~i_bit];

  // ------------------------------------------------------------
  // pin driver, channel 7 wins a shared slot
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_data <= 1'b0;
      o_oe <= 1'b0;
    end else if (i_shift) begin
      if (hit7) begin
        o_data <= exp7;
        o_oe <= 1'b1;
      end else if (hit8) begin
        o_data <= exp8;
        o_oe <= 1'b1;
      end else begin
        o_data <= 1'b0;
        o_oe <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_ch7_drive;
    i_shift && hit7 |=> o_oe && (o_data == $past(exp7));
  endproperty
  a_ch7_drive: assert property (p_ch7_drive) else $error("ch7 bit not driven");

  property p_ch8_drive;
    i_shift && hit8 && !hit7 |=> o_oe && (o_data == $past(exp8));
  endproperty
  a_ch8_drive: assert property (p_ch8_drive) else $error("ch8 bit not driven");

  property p_idle;
    i_shift && !hit7 && !hit8 ##1 !i_shift |-> !o_oe;
  endproperty
  a_idle: assert property (p_idle) else $error("unassigned slot driven");
endmodule
`default_nettype wire

// ==== hw/asc_dummy_none.sv ====
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ==== tb/asc_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module asc_host_model (
  input wire logic i_gen,
  input wire logic i_bclk,
  input wire logic i_fsync,
  input wire logic i_pri,
  input wire logic i_pri_oe,
  input wire logic i_sec,
  input wire logic i_sec_oe,
  output logic o_bclk,
  output logic o_fsync,
  output logic [63:0] o_pri,
  output logic [63:0] o_pri_oe,
  output logic [63:0] o_sec,
  output logic [63:0] o_sec_oe,
  output int o_frames
);
  logic [255:0] w;
  logic fs_q;
  int idx;
  initial begin
    o_bclk = 1'b0;
    o_fsync = 1'b0;
    o_frames = 0;
    fs_q = 1'b0;
    idx = 0;
  end
  // ------------------------------------------------------------
  // host clocks in target role; whole frames back to back while i_gen is high
  // ------------------------------------------------------------
  always begin
    wait (i_gen);
    for (int i = 0; i < 64; i++) begin
      o_fsync = (i == 0);
      #44 o_bclk = 1'b1;
      #44 o_bclk = 1'b0;
    end
    o_fsync = 1'b0;
  end
  // ------------------------------------------------------------
  // receiver: a frame is snapshotted whole at the next frame edge
  // ------------------------------------------------------------
  always @(posedge i_bclk) begin
    if (i_fsync && !fs_q) begin
      {o_pri, o_pri_oe, o_sec, o_sec_oe} = w;
      o_frames++;
      idx = 0;
    end else begin
      idx++;
    end
    fs_q = i_fsync;
    if (idx < 64) begin
      w[255-idx] = i_pri;
      w[191-idx] = i_pri_oe;
      w[127-idx] = i_sec;
      w[63-idx] = i_sec_oe;
    end
  end
endmodule
`default_nettype wire

// ==== tb/asc_port_top_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module asc_port_top_test;
  // ------------------------------------------------------------
  // wiring
  // ------------------------------------------------------------
  localparam logic [31:0] S7 = 32'hA5C3_0F71;
  localparam logic [31:0] S8 = 32'h3C96_E1B4;
  localparam logic [31:0] Z = 32'h0;
  logic clk, rst_n, psel, pen, pwr, gen, pready, pslverr, er;
  logic o_bclk, bclk_oe, o_fs, fs_oe, h_bclk, h_fs, pri, pri_oe, sec, sec_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] cp, cpo, cs, cso;
  logic [15:0] kt [8] = '{16'h2EE0, 16'h3000, 16'h32C8, 16'h3E80, 16'h4B00, 16'h4CE0,
                          16'h5DC0, 16'h6000};
  asc_pkg::asc_clk_cfg_t cfg;
  int frames, err_total, comparisons, bad;
  // the clock pins are two-way: whoever enables drives the wire
  wire bclk_w = bclk_oe ? o_bclk : h_bclk;
  wire fs_w = fs_oe ? o_fs : h_fs;

  asc_port_top #(.BCLK_HALF(4), .FRAME_BCLKS(64)) dut (
    .I_MCLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hF), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_BCLK(bclk_w), .I_FSYNC(fs_w),
    .O_BCLK(o_bclk), .O_BCLK_OE(bclk_oe), .O_FSYNC(o_fs), .O_FSYNC_OE(fs_oe),
    .I_CH7_SAMPLE(S7), .I_CH8_SAMPLE(S8), .O_SAMPLE_TAKE(),
    .O_PRIMARY_SERIAL_OUT_PIN(pri), .O_PRIMARY_SERIAL_OUT_PIN_OE(pri_oe),
    .O_SECONDARY_OUT_PIN_A(sec), .O_SECONDARY_OUT_PIN_A_OE(sec_oe), .O_CLK_CFG(cfg));

  asc_host_model host (
    .i_gen(gen), .i_bclk(bclk_w), .i_fsync(fs_w), .i_pri(pri), .i_pri_oe(pri_oe),
    .i_sec(sec), .i_sec_oe(sec_oe), .o_bclk(h_bclk), .o_fsync(h_fs), .o_pri(cp),
    .o_pri_oe(cpo), .o_sec(cs), .o_sec_oe(cso), .o_frames(frames));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // apb: setup, access held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    repeat (3) @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, Z);
    chk(rd, exp);
  endtask
  task automatic wait_frames(input int k);
    int f0;
    int n;
    f0 = frames;
    n = 0;
    while (frames < f0 + k && n < 6000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 6000) begin
      err_total++;
      stop_test();
    end
  endtask
  // oe bits: primary slot 0, primary slot 1, secondary slot 0, secondary slot 1
  task automatic lanes(input logic [31:0] p0, input logic [31:0] p1, input logic [31:0] s0,
                       input logic [31:0] s1, input logic [3:0] oe);
    wait_frames(3);
    chk(cpo[63:32], {32{oe[3]}});
    chk(cpo[31:0], {32{oe[2]}});
    chk(cso[63:32], {32{oe[1]}});
    chk(cso[31:0], {32{oe[0]}});
    if (oe[3]) chk(cp[63:32], p0);
    if (oe[2]) chk(cp[31:0], p1);
    if (oe[1]) chk(cs[63:32], s0);
    if (oe[0]) chk(cs[31:0], s1);
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    err_total = 0;
    comparisons = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    gen = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(8'h44, 32'h06);
    rdc(8'h48, 32'h07);
    rdc(8'h4C, 32'h02);
    chk(32'(cfg.controller), Z);
    chk(32'(cfg.auto_derive), 32'h1);
    chk(32'(cfg.pll_enable), 32'h1);
    $display("reset values done");
    wr(8'h44, 32'hFF);
    rdc(8'h44, 32'h7F);
    wr(8'h48, 32'hC5);
    rdc(8'h48, 32'h45);
    xfer(1'b0, 8'h00, Z);
    chk(rd, Z);
    chk(32'(er), 32'h1);
    $display("register access done");
    for (int c = 0; c < 8; c++) begin
      wr(8'h4C, 32'h80 | c);
      chk(32'(cfg.ref_khz), 32'(kt[c]));
      chk(32'(cfg.controller), 32'h1);
    end
    wr(8'h4C, 32'h88);
    chk(32'(cfg.family_441), 32'h1);
    wr(8'h4C, 32'hC0);
    chk(32'(cfg.auto_derive), Z);
    wr(8'h4C, 32'hA0);
    chk(32'(cfg.pll_enable), Z);
    wr(8'h4C, 32'h20);
    wr(8'hC0, 32'h2C);
    chk({30'h0, cfg.root_valid, cfg.root_from_refclk}, 32'h3);
    wr(8'hC0, 32'h0C);
    chk({30'h0, cfg.root_valid, cfg.root_from_refclk}, 32'h2);
    wr(8'h4C, 32'h82);
    wr(8'hC0, 32'h1C);
    chk(32'(cfg.ref_from_ratio), 32'h1);
    wr(8'hC0, 32'h0C);
    chk(32'(cfg.ref_from_ratio), Z);
    chk(32'(cfg.ref_khz), 32'h32C8);
    $display("clock configuration done");
    wr(8'h44, 32'h00);
    wr(8'h48, 32'h41);
    wr(8'h4C, 32'h80);
    lanes(S7, Z, Z, S8, 4'h9);
    wr(8'h44, 32'h41);
    wr(8'h48, 32'h00);
    lanes(S8, Z, Z, S7, 4'h9);
    wr(8'hC0, 32'h0E);
    wr(8'h44, 32'h20);
    lanes(S8, S7, Z, Z, 4'hC);
    $display("controller frames done");
    wr(8'hC0, 32'h0C);
    wr(8'h4C, 32'h90);
    repeat (20) @(posedge clk);
    bad = 0;
    repeat (64) begin
      @(posedge clk);
      if (o_bclk !== 1'b0 || o_fs !== 1'b0) bad++;
    end
    chk(32'(bad), Z);
    chk(32'(bclk_oe), 32'h1);
    $display("clock gate done");
    wr(8'h44, 32'h00);
    wr(8'h48, 32'h41);
    wr(8'h4C, 32'h10);
    gen = 1'b1;
    wait_frames(3);
    chk(32'(bclk_oe), Z);
    chk(32'($countones(cpo)), 32'h20);
    chk(32'($countones(cso)), 32'h20);
    gen = 1'b0;
    $display("target frames done");
    stop_test();
  end
endmodule
`default_nettype wire
